/* File: hw/universal_serial_shift_unit.sv */
// Operation
// - 8-bit shift register, read and written directly
// - no receive buffer; shifting overwrites received data
// - msb drives three-wire or two-wire output pin
// - external clock: output changes on edge opposite to sampling
// - input always sampled from data input pin
// - 4-bit counter, read/write, overflow request
// - register and counter advance from one source
// - external clock: counter counts both edges
// - three shift sources: pin, timer, strobe
// - detect two-wire start, raise request
// - two-wire: hold clock low after start or overflow
// - three-wire acts as spi mode 0/1
// - eight clocks exchange both registers fully
// - overflow flag marks transfer complete
// - master toggles clock pin via strobe
// - wake request from flags, two-wire start too
// - polarity clear: sample rising, shift falling
// - polarity set: sample falling, shift rising
// - sixteen counted edges overflow the counter
// - data falling while clock high is start
`timescale 1ns/1ns
`default_nettype none

module universal_serial_shift_unit
  import serial_unit_pkg::*;
#(
  parameter int DWIDTH = DATA_WIDTH,
  parameter int CWIDTH = COUNT_WIDTH
) (
  // system clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // link clock, the serial clock as seen on its pin
  input wire logic i_serial_clock,
  // serial pins
  input wire logic i_serial_data_in_pin,
  input wire logic i_serial_clock_pin,
  output logic o_data_out_pin,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_serial_clock_out,
  output logic o_serial_clock_oe,
  // configuration
  input wire logic i_two_wire_mode,
  input wire logic i_external_clock_polarity_select,
  input wire logic [1:0] i_clock_source,
  input wire logic i_clock_pin_drive,
  input wire logic i_start_hold_enable,
  input wire logic i_overflow_hold_enable,
  // clock events
  input wire logic i_clock_toggle_strobe,
  input wire logic i_shift_strobe,
  input wire logic i_timer_match,
  // processor access
  input wire logic i_data_write,
  input wire logic [DWIDTH-1:0] i_data_wdata,
  output logic [DWIDTH-1:0] o_data,
  input wire logic i_count_write,
  input wire logic [CWIDTH-1:0] i_count_wdata,
  output logic [CWIDTH-1:0] o_count,
  input wire logic i_clear_overflow,
  input wire logic i_clear_start,
  // status
  output logic o_counter_overflow_flag,
  output logic o_start_condition_flag,
  output logic o_wake
);

  ////////////////////////////////////////////////////////////////////////////
  // link domain capture and crossing

  serial_link_if lnk ();

  logic [LINK_WORD_WIDTH-1:0] link_word;
  logic [LINK_WORD_WIDTH-1:0] link_sync;
  logic [2:0] pin_sync;
  logic [1:0] pos_seen;
  logic [1:0] neg_seen;
  logic data_in;
  logic scl_in;
  logic sda_prev;
  logic scl_prev;

  link_edge_capture u_capture (
    .i_serial_clock(i_serial_clock),
    .i_rst_b(i_rst_b),
    .i_data_pin(i_serial_data_in_pin),
    .lnk(lnk.capture)
  );

  // a bit is read a cycle after its toggle shows, so it has settled
  assign link_word[LINK_POS_TOGGLE] = lnk.pos_toggle;
  assign link_word[LINK_POS_BIT] = lnk.pos_bit;
  assign link_word[LINK_NEG_TOGGLE] = lnk.neg_toggle;
  assign link_word[LINK_NEG_BIT] = lnk.neg_bit;

  level_sync #(.WIDTH(LINK_WORD_WIDTH)) u_link_sync (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_async(link_word),
    .o_sync(link_sync)
  );

  // raw pins for the internal clock sources and the start detector
  level_sync #(.WIDTH(3)) u_pin_sync (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_async({i_serial_clock_pin, i_serial_data_in_pin, 1'b0}),
    .o_sync(pin_sync)
  );

  assign scl_in = pin_sync[2];
  assign data_in = pin_sync[1];

  // previous levels for edge detection, only after synchronisation
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pos_seen <= 2'h0;
      neg_seen <= 2'h0;
      sda_prev <= 1'b1;
      scl_prev <= 1'b0;
    end else begin
      pos_seen <= {pos_seen[0], link_sync[LINK_POS_TOGGLE]};
      neg_seen <= {neg_seen[0], link_sync[LINK_NEG_TOGGLE]};
      sda_prev <= data_in;
      scl_prev <= scl_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock source selection

  clock_source_t source;
  logic pos_event;
  logic neg_event;
  logic sample_event;
  logic change_event;
  logic sample_bit;
  logic internal_tick;
  logic [1:0] count_step;

  assign source = clock_source_t'(i_clock_source);
  assign pos_event = pos_seen[1] ^ pos_seen[0];
  assign neg_event = neg_seen[1] ^ neg_seen[0];

  // one source drives both register and counter
  always_comb begin
    internal_tick = 1'b0;
    sample_event = 1'b0;
    change_event = 1'b0;
    sample_bit = data_in;
    count_step = 2'b00;
    unique case (source)
      SRC_PIN: begin
        if (i_external_clock_polarity_select) begin
          sample_event = neg_event;
          change_event = pos_event;
          sample_bit = link_sync[LINK_NEG_BIT];
        end else begin
          sample_event = pos_event;
          change_event = neg_event;
          sample_bit = link_sync[LINK_POS_BIT];
        end
        count_step = {1'b0, pos_event} + {1'b0, neg_event};
      end
      SRC_TIMER: begin
        internal_tick = i_timer_match;
      end
      SRC_STROBE: begin
        internal_tick = i_shift_strobe;
      end
      SRC_NONE: begin
        internal_tick = 1'b0;
      end
    endcase
    if (internal_tick) begin
      sample_event = 1'b1;
      count_step = 2'b01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift register and output latch

  logic [DWIDTH-1:0] shift_data;
  logic out_bit;

  // no receive buffer: each shifted bit replaces older contents
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shift_data <= DATA_RESET;
    end else if (i_data_write) begin
      shift_data <= i_data_wdata;
    end else if (sample_event) begin
      shift_data <= {shift_data[DWIDTH-2:0], sample_bit};
    end
  end

  // external clock: hold msb until the edge opposite the sampling one;
  // internal sources have no such edge, so the latch stays transparent
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      out_bit <= 1'b0;
    end else if (source != SRC_PIN || change_event || i_data_write) begin
      out_bit <= i_data_write ? i_data_wdata[DWIDTH-1]
                              : shift_data[DWIDTH-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge counter and overflow

  logic [CWIDTH-1:0] count;
  logic [CWIDTH:0] count_sum;
  logic wrap;
  logic overflow_flag;

  assign count_sum = {1'b0, count} + {{(CWIDTH-1){1'b0}}, count_step};
  assign wrap = count_sum[CWIDTH];

  // counter advances with the shift register
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count <= COUNT_RESET;
    end else if (i_count_write) begin
      count <= i_count_wdata;
    end else begin
      count <= count_sum[CWIDTH-1:0];
    end
  end

  // a wrap in the clearing cycle still sets the flag
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      overflow_flag <= 1'b0;
    end else if (wrap && !i_count_write) begin
      overflow_flag <= 1'b1;
    end else if (i_clear_overflow) begin
      overflow_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // start detector and clock hold

  logic start_seen;
  logic start_flag;
  logic start_hold;
  logic hold;

  assign start_seen = i_two_wire_mode && scl_in && sda_prev && !data_in;

  // set wins over a clear in the same cycle
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      start_flag <= 1'b0;
    end else if (start_seen) begin
      start_flag <= 1'b1;
    end else if (i_clear_start) begin
      start_flag <= 1'b0;
    end
  end

  // hold engages at the first falling clock after a start
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      start_hold <= 1'b0;
    end else if (!start_flag || !i_start_hold_enable) begin
      start_hold <= 1'b0;
    end else if (scl_prev && !scl_in) begin
      start_hold <= 1'b1;
    end
  end

  assign hold = i_two_wire_mode && (start_hold ||
                (i_overflow_hold_enable && overflow_flag));

  ////////////////////////////////////////////////////////////////////////////
  // master clock generation

  logic clock_level;

  // the strobe flips the driven clock level
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      clock_level <= 1'b0;
    end else if (i_clock_toggle_strobe) begin
      clock_level <= ~clock_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  // three-wire uses no slave select; the peer clocks the exchange unless i_clock_pin_drive drives clock_level
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_data_out_pin <= 1'b0;
      o_sda_out <= 1'b0;
      o_sda_oe <= 1'b0;
      o_serial_clock_out <= 1'b0;
      o_serial_clock_oe <= 1'b0;
    end else begin
      o_data_out_pin <= i_two_wire_mode ? 1'b0 : out_bit;
      o_sda_out <= 1'b0;
      o_sda_oe <= i_two_wire_mode && !out_bit;
      o_serial_clock_out <= hold ? 1'b0 : clock_level;
      o_serial_clock_oe <= hold || (i_clock_pin_drive && !i_two_wire_mode)
                           || (i_clock_pin_drive && !clock_level);
    end
  end

  // status outputs, one cycle behind the internal state
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_data <= DATA_RESET;
      o_count <= COUNT_RESET;
      o_counter_overflow_flag <= 1'b0;
      o_start_condition_flag <= 1'b0;
      o_wake <= 1'b0;
    end else begin
      o_data <= shift_data;
      o_count <= count;
      o_counter_overflow_flag <= overflow_flag;
      o_start_condition_flag <= start_flag;
      o_wake <= overflow_flag || start_flag;
    end
  end

endmodule : universal_serial_shift_unit

`default_nettype wire

/* File: hw/serial_unit_pkg.sv */
package serial_unit_pkg;

  // shift register and counter widths
  localparam int DATA_WIDTH = 8;
  localparam int COUNT_WIDTH = 4;

  // reset values, and the last count before a wrap
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [3:0] COUNT_RESET = 4'h0;
  localparam logic [3:0] COUNT_LAST = 4'hf;

  // depth of every synchroniser into the system clock domain
  localparam int SYNC_STAGES = 2;

  // field position of the link capture word crossing into the core
  localparam int LINK_POS_TOGGLE = 0;
  localparam int LINK_POS_BIT = 1;
  localparam int LINK_NEG_TOGGLE = 2;
  localparam int LINK_NEG_BIT = 3;
  localparam int LINK_WORD_WIDTH = 4;

  // shift clock source select
  typedef enum logic [1:0] {
    SRC_PIN = 2'b00,
    SRC_TIMER = 2'b01,
    SRC_STROBE = 2'b10,
    SRC_NONE = 2'b11
  } clock_source_t;

endpackage : serial_unit_pkg

/* File: hw/serial_link_if.sv */
`timescale 1ns/1ns
`default_nettype none

// events captured on the serial clock, handed to the system clock domain
interface serial_link_if;
  logic pos_toggle;
  logic pos_bit;
  logic neg_toggle;
  logic neg_bit;

  modport capture (
    output pos_toggle,
    output pos_bit,
    output neg_toggle,
    output neg_bit
  );

  modport core (
    input pos_toggle,
    input pos_bit,
    input neg_toggle,
    input neg_bit
  );
endinterface : serial_link_if

`default_nettype wire

/* File: hw/level_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module level_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // levels from another domain
  input wire logic [WIDTH-1:0] i_async,
  // levels safe to read
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage_one;

  // first stage is read only by the second stage
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stage_one <= '0;
      o_sync <= '0;
    end else begin
      stage_one <= i_async;
      o_sync <= stage_one;
    end
  end

endmodule : level_sync

`default_nettype wire

/* File: hw/link_edge_capture.sv */
`timescale 1ns/1ns
`default_nettype none

module link_edge_capture (
  // link clock and reset
  input wire logic i_serial_clock,
  input wire logic i_rst_b,
  // data input pin, stable around the link clock edges
  input wire logic i_data_pin,
  // captured edges
  serial_link_if.capture lnk
);

  // rising edge: sample data and flag the edge by a toggle
  always_ff @(posedge i_serial_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lnk.pos_toggle <= 1'b0;
      lnk.pos_bit <= 1'b0;
    end else begin
      lnk.pos_bit <= i_data_pin;
      lnk.pos_toggle <= ~lnk.pos_toggle;
    end
  end

  // falling edge: same capture, so either polarity can pick its edge
  always_ff @(negedge i_serial_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lnk.neg_toggle <= 1'b0;
      lnk.neg_bit <= 1'b0;
    end else begin
      lnk.neg_bit <= i_data_pin;
      lnk.neg_toggle <= ~lnk.neg_toggle;
    end
  end

endmodule : link_edge_capture

`default_nettype wire

/* File: verification/universal_serial_shift_unit_props.sv */
`timescale 1ns/1ns
`default_nettype none

module universal_serial_shift_unit_props
  import serial_unit_pkg::*;
#(
  parameter int DWIDTH = DATA_WIDTH,
  parameter int CWIDTH = COUNT_WIDTH
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // watched inputs
  input wire logic i_serial_clock_pin,
  input wire logic i_two_wire_mode,
  input wire logic [1:0] i_clock_source,
  input wire logic i_clock_pin_drive,
  input wire logic i_shift_strobe,
  input wire logic i_timer_match,
  input wire logic i_data_write,
  input wire logic [DWIDTH-1:0] i_data_wdata,
  input wire logic i_count_write,
  input wire logic [CWIDTH-1:0] i_count_wdata,
  input wire logic i_clear_overflow,
  // watched outputs
  input wire logic [DWIDTH-1:0] o_data,
  input wire logic [CWIDTH-1:0] o_count,
  input wire logic o_data_out_pin,
  input wire logic o_sda_oe,
  input wire logic o_serial_clock_oe,
  input wire logic o_counter_overflow_flag,
  input wire logic o_start_condition_flag
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  // an internal shift event; a write in the same cycle overrules it
  logic tick;
  assign tick = !i_count_write && !i_data_write &&
    ((i_clock_source == SRC_STROBE && i_shift_strobe) ||
     (i_clock_source == SRC_TIMER && i_timer_match));

  ////////////////////////////////////////////////////////////////////////
  property p_data_write;
    i_data_write |-> ##2 o_data == $past(i_data_wdata, 2);
  endproperty
  a_data_write: assert property (p_data_write)
    else $error("shift register write not seen");
  property p_count_write;
    i_count_write |-> ##2 o_count == $past(i_count_wdata, 2);
  endproperty
  a_count_write: assert property (p_count_write)
    else $error("counter write not seen");
  property p_count_step;
    tick |-> ##2 o_count == $past(o_count) + 4'h1;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter missed a shift event");
  property p_flag_wrap;
    $rose(o_counter_overflow_flag) |->
      o_count == COUNT_RESET && $past(o_count) == COUNT_LAST;
  endproperty
  a_flag_wrap: assert property (p_flag_wrap)
    else $error("overflow flag without a wrap");
  property p_flag_hold;
    o_counter_overflow_flag && !i_clear_overflow &&
      !$past(i_clear_overflow) |=> o_counter_overflow_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("overflow flag dropped uncleared");
  property p_wire_out;
    $stable(i_two_wire_mode) [*3] |->
      (i_two_wire_mode ? !o_data_out_pin : !o_sda_oe);
  endproperty
  a_wire_out: assert property (p_wire_out)
    else $error("msb on the wrong output pin");
  property p_start_scl;
    $rose(o_start_condition_flag) |->
      i_two_wire_mode && $past(i_serial_clock_pin, 4);
  endproperty
  a_start_scl: assert property (p_start_scl)
    else $error("start flag without clock high");
  property p_hold_free;
    (!o_start_condition_flag && !o_counter_overflow_flag &&
      !i_clock_pin_drive) [*4] |-> !o_serial_clock_oe;
  endproperty
  a_hold_free: assert property (p_hold_free)
    else $error("clock held with no flag");
endmodule : universal_serial_shift_unit_props

bind universal_serial_shift_unit universal_serial_shift_unit_props #(
  .DWIDTH(DWIDTH),
  .CWIDTH(CWIDTH)
) u_universal_serial_shift_unit_props (.*);

`default_nettype wire

/* File: verification/serial_peer_model.sv */
`timescale 1ns/1ns
`default_nettype none

module serial_peer_model (
  // link rate reference
  input wire logic i_link_ref,
  // device data output
  input wire logic i_peer_in,
  // peer clock and data
  output logic o_sclk,
  output logic o_sdo,
  output logic [7:0] o_rx
);
  // clock stands still low between frames
  initial begin
    o_sclk = 1'b0;
    o_sdo = 1'b0;
    o_rx = 8'h00;
  end

  // three link periods, so the core never merges two edges
  task automatic gap();
    repeat (3) @(posedge i_link_ref);
  endtask : gap

  // one byte msb first; pol picks the sampling edge
  task automatic transfer(input logic [7:0] tx, input logic pol);
    for (int k = 7; k >= 0; k--) begin
      if (!pol) o_sdo = tx[k];
      gap();
      o_sclk = 1'b1;
      if (pol) o_sdo = tx[k];
      else o_rx = {o_rx[6:0], i_peer_in};
      gap();
      o_sclk = 1'b0;
      if (pol) o_rx = {o_rx[6:0], i_peer_in};
    end
    gap();
    // a released line never shows the held bit
    o_sdo = ~o_sdo;
  endtask : transfer
endmodule : serial_peer_model

`default_nettype wire

/* File: verification/universal_serial_shift_unit_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module universal_serial_shift_unit_tb_top
  import serial_unit_pkg::*;
;
  // bench controls
  logic clk, rst_b, link_ref, two_wire, pol, hold_en, use_peer;
  logic shift, timer, dwr, cwr, clr_of, clr_st, tb_scl, tb_sda;
  logic drive, tgl, of_hold;
  logic [1:0] src;
  logic [7:0] wdata;
  logic [3:0] cwdata;
  // design and peer outputs
  logic dout_pin, sda_out, sda_oe, scl_out, scl_oe, of_flag, st_flag;
  logic wake, p_sclk, p_sdo;
  logic [7:0] data, p_rx;
  logic [3:0] count;
  wire scl, sda, din;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;

  // open drain lines pull high unless someone sinks them
  assign sda = tb_sda & !sda_oe;
  assign scl = two_wire ? (tb_scl & !(scl_oe & !scl_out)) : p_sclk;
  assign din = two_wire ? sda : (use_peer ? p_sdo : tb_sda);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // link reference, unrelated in phase
  initial begin
    link_ref = 1'b0;
    #7;
    forever #40 link_ref = ~link_ref;
  end

  universal_serial_shift_unit u_universal_serial_shift_unit (
    .i_clock(clk),
    .i_rst_b(rst_b),
    .i_serial_clock(scl),
    .i_serial_data_in_pin(din),
    .i_serial_clock_pin(scl),
    .o_data_out_pin(dout_pin),
    .o_sda_out(sda_out),
    .o_sda_oe(sda_oe),
    .o_serial_clock_out(scl_out),
    .o_serial_clock_oe(scl_oe),
    .i_two_wire_mode(two_wire),
    .i_external_clock_polarity_select(pol),
    .i_clock_source(src),
    .i_clock_pin_drive(drive),
    .i_start_hold_enable(hold_en),
    .i_overflow_hold_enable(of_hold),
    .i_clock_toggle_strobe(tgl),
    .i_shift_strobe(shift),
    .i_timer_match(timer),
    .i_data_write(dwr),
    .i_data_wdata(wdata),
    .o_data(data),
    .i_count_write(cwr),
    .i_count_wdata(cwdata),
    .o_count(count),
    .i_clear_overflow(clr_of),
    .i_clear_start(clr_st),
    .o_counter_overflow_flag(of_flag),
    .o_start_condition_flag(st_flag),
    .o_wake(wake)
  );
  serial_peer_model u_serial_peer_model (
    .i_link_ref(link_ref),
    .i_peer_in(dout_pin),
    .o_sclk(p_sclk),
    .o_sdo(p_sdo),
    .o_rx(p_rx)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (!ok) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk

  // stimulus tasks open with a cycle wait, so they drive just after a rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // load a byte, zero the counter, clear overflow
  task automatic setup(input logic [7:0] d);
    cyc(1);
    dwr <= 1'b1;
    wdata <= d;
    cwr <= 1'b1;
    cwdata <= 4'h0;
    clr_of <= 1'b1;
    cyc(1);
    dwr <= 1'b0;
    cwr <= 1'b0;
    clr_of <= 1'b0;
    cyc(2);
  endtask : setup

  // eight tick slots, sources alternating, din settled first
  task automatic ticks(input logic [7:0] b, input logic [1:0] s);
    for (int k = 7; k >= 0; k--) begin
      cyc(1);
      tb_sda <= b[k];
      cyc(3);
      src <= k[0] ? s : SRC_TIMER;
      shift <= 1'b1;
      timer <= 1'b1;
      cyc(1);
      shift <= 1'b0;
      timer <= 1'b0;
    end
    cyc(3);
    @(negedge clk);
  endtask : ticks

  ////////////////////////////////////////////////////////////////////////
  task automatic t_internal();
    setup(8'hc3);
    @(negedge clk);
    chk(data === 8'hc3 && count === 4'h0, "write");
    chk(dout_pin === 1'b1, "msb out");
    ticks(8'h96, SRC_STROBE);
    chk(data === 8'h96 && count === 4'h8, "byte");
    ticks(8'ha5, SRC_STROBE);
    chk(data === 8'ha5 && count === 4'h0, "wrap");
    chk(of_flag === 1'b1, "overflow");
    ticks(8'hff, SRC_NONE);
    // only the four timer slots tick; the unused source adds nothing
    chk(count === 4'h4, "no source");
    chk(of_flag === 1'b1, "flag kept");
    cyc(1);
    clr_of <= 1'b1;
    cyc(1);
    clr_of <= 1'b0;
    cyc(2);
    @(negedge clk);
    chk(of_flag === 1'b0, "flag cleared");
  endtask : t_internal

  task automatic t_spi(input logic p, input logic [7:0] tx, rx);
    cyc(1);
    src <= SRC_PIN;
    pol <= p;
    use_peer <= 1'b1;
    setup(tx);
    u_serial_peer_model.transfer(rx, p);
    cyc(8);
    @(negedge clk);
    chk(data === rx && p_rx === tx, "exchange");
    chk(count === 4'h0 && of_flag === 1'b1, "edges");
    cyc(1);
    use_peer <= 1'b0;
  endtask : t_spi

  task automatic t_start();
    cyc(1);
    two_wire <= 1'b1;
    src <= SRC_NONE;
    hold_en <= 1'b1;
    clr_of <= 1'b1;
    tb_sda <= 1'b1;
    cyc(1);
    clr_of <= 1'b0;
    tb_scl <= 1'b0;
    cyc(4);
    tb_sda <= 1'b0;
    cyc(4);
    tb_scl <= 1'b1;
    cyc(4);
    tb_sda <= 1'b1;
    cyc(6);
    chk(st_flag === 1'b0, "clock low fall");
    tb_sda <= 1'b0;
    cyc(6);
    chk(st_flag === 1'b1 && wake === 1'b1, "start");
    tb_scl <= 1'b0;
    cyc(5);
    chk(scl_oe === 1'b1 && scl_out === 1'b0, "held");
    clr_st <= 1'b1;
    cyc(1);
    clr_st <= 1'b0;
    cyc(4);
    chk(scl_oe === 1'b0 && st_flag === 1'b0, "released");
  endtask : t_start

  // strobe-driven master clock, msb on sda, hold after overflow
  task automatic t_master();
    cyc(1);
    two_wire <= 1'b0;
    drive <= 1'b1;
    for (int k = 1; k >= 0; k--) begin
      cyc(1);
      tgl <= 1'b1;
      cyc(1);
      tgl <= 1'b0;
      cyc(3);
      @(negedge clk);
      chk(scl_oe === 1'b1 && scl_out === k[0], "toggle");
    end
    cyc(1);
    two_wire <= 1'b1;
    drive <= 1'b0;
    of_hold <= 1'b1;
    src <= SRC_STROBE;
    setup(8'h7f);
    @(negedge clk);
    chk(sda_oe === 1'b1 && sda_out === 1'b0, "msb on sda");
    cyc(1);
    cwr <= 1'b1;
    cwdata <= 4'hf;
    cyc(1);
    cwr <= 1'b0;
    shift <= 1'b1;
    cyc(1);
    shift <= 1'b0;
    cyc(3);
    @(negedge clk);
    chk(of_flag === 1'b1 && scl_oe === 1'b1, "overflow hold");
    chk(scl_out === 1'b0, "held low");
    chk(sda_oe === 1'b0, "sda released");
    cyc(1);
    clr_of <= 1'b1;
    cyc(1);
    clr_of <= 1'b0;
    of_hold <= 1'b0;
    cyc(3);
    @(negedge clk);
    chk(of_flag === 1'b0 && scl_oe === 1'b0, "hold released");
  endtask : t_master

  // a hung run still reaches the verdict
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    {rst_b, two_wire, pol, hold_en, use_peer, shift, timer} = 7'h00;
    {dwr, cwr, clr_of, clr_st, src, wdata, cwdata} = 18'h00000;
    {tb_scl, tb_sda} = 2'h3;
    {drive, tgl, of_hold} = 3'h0;
    cyc(4);
    rst_b <= 1'b1;
    cyc(3);
    @(negedge clk);
    chk({data, count, of_flag, st_flag} === 14'h0000, "reset");
    t_internal();
    t_spi(1'b0, 8'h3c, 8'h5a);
    t_spi(1'b1, 8'h69, 8'ha6);
    t_start();
    t_master();
    summarize();
  end
endmodule : universal_serial_shift_unit_tb_top

`default_nettype wire
